// [hdl/kwd_pkg.sv]
// Constants, register map and ratio decode for the keyed watchdog
// Assumes a single system clock and a slow oscillator sampled as a pin
// Function
// - Counter runs from the slow internal oscillator, dividing by two to the 8..18.
// - Select codes 000..110 give 2^8,2^10,2^12,2^14,2^15,2^16,2^17 cycles.
// - Key 10101 disables the watchdog, key 01010 enables it.
// - Any other key resets the device after 2 to 3 oscillator cycles.
// - A key reset sets bit 0 of the reset cause register.
// - That flag stays set until software writes 0 to it.
// - Control resets to key 01010 and select 011.
// - Timeout while running resets the device and sets the timeout flag.
// - Timeout asleep sets the flag and resets only program counter and stack pointer.
// - Key reset, clear instruction or halt clears the counter.
// - Upper four bits of the reset cause register read as zero.
// - Halt clears the counter, which then runs only if enabled.
package kwd_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          CNT_W         = 18;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CAUSE     = 8'h04;
	localparam logic [7:0]  OFF_ISTAT     = 8'h08;
	localparam logic [7:0]  OFF_IMASK     = 8'h0C;
	localparam logic [7:0]  OFF_STATUS    = 8'h10;
	localparam logic [7:0]  OFF_COUNT     = 8'h14;
	localparam logic [7:0]  CTRL_RST      = 8'h53;
	localparam int          KEY_LSB       = 3;
	localparam logic [4:0]  KEY_ENABLE    = 5'h0A;
	localparam logic [4:0]  KEY_DISABLE   = 5'h15;
	localparam int          CAUSE_KEY_BIT = 0;
	localparam int          IRQ_TIMEOUT   = 0;
	localparam int          IRQ_KEYRST    = 1;
	localparam int          IRQ_W         = 2;
	localparam logic [1:0]  KEY_FIRE_TICK = 2'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Terminal count, ratio minus one, for a select code
	function automatic logic [17:0] ratio_m1(input logic [2:0] sel);
		logic [4:0] sh;
		sh = 5'd18;
		unique case (sel)
			3'h0: sh = 5'd8;
			3'h1: sh = 5'd10;
			3'h2: sh = 5'd12;
			3'h3: sh = 5'd14;
			3'h4: sh = 5'd15;
			3'h5: sh = 5'd16;
			3'h6: sh = 5'd17;
			3'h7: sh = 5'd18;
		endcase
		ratio_m1 = 18'((19'h0_0001 << sh) - 19'h0_0001);
	endfunction
endpackage

// [hdl/kwd_cnt_if.sv]
// Bundle between watchdog control, oscillator tick and divider counter
// Assumes all members are on the system clock
`timescale 1ns/1ps
`default_nettype none
interface kwd_cnt_if;
	logic        tick;
	logic        run;
	logic        clear;
	logic [2:0]  sel;
	logic        expire;
	logic [17:0] count;
	modport src (output tick);
	modport cnt (input tick, input run, input clear, input sel, output expire, output count);
	modport ctl (input tick, output run, output clear, output sel, input expire, input count);
endinterface
`default_nettype wire

// [hdl/kwd_low_speed_internal_osc_tick.sv]
// Turns the slow oscillator pin into one system-clock tick per rising edge
// Assumes the oscillator is far slower than the system clock
`timescale 1ns/1ps
`default_nettype none
module kwd_low_speed_internal_osc_tick (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	input  wire logic low_speed_internal_osc_clk_i,
	kwd_cnt_if.src    tk
);
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic tick_q;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			tick_q  <= 1'b0;
		end else begin
			sync1_q <= low_speed_internal_osc_clk_i;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			tick_q  <= sync2_q & ~prev_q;
		end
	end

	assign tk.tick = tick_q;
endmodule // kwd_low_speed_internal_osc_tick
`default_nettype wire

// [hdl/kwd_div_counter.sv]
// Watchdog divider: counts oscillator ticks up to the selected ratio
// Assumes clear and run come from the control logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module kwd_div_counter (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	kwd_cnt_if.cnt    dc
);
	logic [17:0] cnt_q;
	logic [17:0] cnt_d;
	logic        exp_q;
	wire  [17:0] term = kwd_pkg::ratio_m1(dc.sel);
	wire         hit  = dc.tick & dc.run & (cnt_q >= term);

	// Compare with >= so a shorter select taken mid-count still expires
	assign cnt_d = dc.clear ? 18'h0_0000 :
	               hit ? 18'h0_0000 :
	               (dc.tick & dc.run) ? cnt_q + 18'h0_0001 : cnt_q;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= 18'h0_0000;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= hit & ~dc.clear;
		end
	end

	assign dc.count  = cnt_q;
	assign dc.expire = exp_q;
endmodule // kwd_div_counter
`default_nettype wire

// [hdl/kwd_top.sv]
// Keyed watchdog: key guard, reset outputs, flags and AXI4-Lite registers
// Assumes CPU strobes are one-cycle pulses on clk_sys_i; oscillator is a pin
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module kwd_top (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        low_speed_internal_osc_clk_i,
	input  wire logic        clear_watchdog_instruction_i,
	input  wire logic        halt_i,
	input  wire logic        sleep_i,
	output logic             dev_reset_o,
	output logic             pc_sp_reset_o,
	output logic             timeout_status_flag_o,
	output logic             irq_o,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	kwd_cnt_if cif ();

	kwd_low_speed_internal_osc_tick u_tick (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.low_speed_internal_osc_clk_i (low_speed_internal_osc_clk_i),
		.tk         (cif)
	);

	kwd_div_counter u_div (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.dc        (cif)
	);

	// Control state
	logic [7:0]  ctrl_q;
	logic        key_flag_q;
	logic        to_flag_q;
	logic [1:0]  istat_q;
	logic [1:0]  imask_q;
	logic        irq_q;
	logic        pend_q;
	logic [1:0]  pend_ticks_q;
	logic        dev_rst_q;
	logic        pcsp_rst_q;

	// Bus state
	logic        awrdy_q;
	logic        wrdy_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arrdy_q;
	logic [7:0]  raddr_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// Key decode
	wire [4:0] key       = ctrl_q[7:kwd_pkg::KEY_LSB];
	wire       key_en    = (key == kwd_pkg::KEY_ENABLE);
	wire       key_dis   = (key == kwd_pkg::KEY_DISABLE);
	wire       key_bad   = ~key_en & ~key_dis;
	wire       key_fire  = pend_q & cif.tick & (pend_ticks_q == kwd_pkg::KEY_FIRE_TICK);
	wire       to_wake   = cif.expire & ~sleep_i;
	wire       to_sleep  = cif.expire & sleep_i;
	wire       dev_fire  = key_fire | to_wake;

	assign cif.sel   = ctrl_q[2:0];
	assign cif.run   = key_en & ~pend_q;
	assign cif.clear = key_fire | clear_watchdog_instruction_i | halt_i;

	// Write decode
	wire       wr_go     = aw_got_q & w_got_q & ~bvalid_q;
	wire       wr_lane0  = wr_go & wstrb_q[0];
	wire       wr_ctrl   = wr_lane0 & (waddr_q == kwd_pkg::OFF_CTRL);
	wire       wr_cause  = wr_lane0 & (waddr_q == kwd_pkg::OFF_CAUSE);
	wire       wr_istat  = wr_lane0 & (waddr_q == kwd_pkg::OFF_ISTAT);
	wire       wr_imask  = wr_lane0 & (waddr_q == kwd_pkg::OFF_IMASK);
	wire       cause_clr = wr_cause & ~wdata_q[kwd_pkg::CAUSE_KEY_BIT];
	wire       wr_hit    = (waddr_q == kwd_pkg::OFF_CTRL) | (waddr_q == kwd_pkg::OFF_CAUSE) |
	                       (waddr_q == kwd_pkg::OFF_ISTAT) | (waddr_q == kwd_pkg::OFF_IMASK) |
	                       (waddr_q == kwd_pkg::OFF_STATUS) | (waddr_q == kwd_pkg::OFF_COUNT);

	// Read decode
	wire       rd_go     = s_axi_arvalid & arrdy_q;
	// Low address bits ignored on reads as on writes
	wire [7:0] rd_addr   = {s_axi_araddr[7:2], 2'b00};
	logic [31:0] rd_val;
	logic        rd_hit;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (rd_addr)
			kwd_pkg::OFF_CTRL:   rd_val[7:0] = ctrl_q;
			kwd_pkg::OFF_CAUSE:  rd_val[kwd_pkg::CAUSE_KEY_BIT] = key_flag_q;
			kwd_pkg::OFF_ISTAT:  rd_val[1:0] = istat_q;
			kwd_pkg::OFF_IMASK:  rd_val[1:0] = imask_q;
			kwd_pkg::OFF_STATUS: rd_val[3:0] = {key_dis, key_en, pend_q, to_flag_q};
			kwd_pkg::OFF_COUNT:  rd_val[17:0] = cif.count;
			default:             rd_hit = 1'b0;
		endcase
	end

	// Interrupt status next value; hardware set wins over software clear
	wire [1:0] ev      = {key_fire, cif.expire};
	wire [1:0] istat_d = (istat_q & ~(wr_istat ? wdata_q[1:0] : 2'h0)) | ev;

	// Key guard and control register
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q       <= kwd_pkg::CTRL_RST;
			pend_q       <= 1'b0;
			pend_ticks_q <= 2'h0;
		end else begin
			if (dev_fire) begin
				// Device reset returns control to its power-on value
				ctrl_q <= kwd_pkg::CTRL_RST;
			end else if (wr_ctrl) begin
				ctrl_q <= wdata_q[7:0];
			end
			if (key_fire) begin
				pend_q       <= 1'b0;
				pend_ticks_q <= 2'h0;
			end else if (!pend_q && key_bad) begin
				// Once armed the reset is not withdrawn by a later good key
				pend_q       <= 1'b1;
				pend_ticks_q <= 2'h0;
			end else if (pend_q && cif.tick) begin
				pend_ticks_q <= pend_ticks_q + 2'h1;
			end
		end
	end

	// Flags and reset pulses
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			key_flag_q <= 1'b0;
			to_flag_q  <= 1'b0;
			istat_q    <= 2'h0;
			imask_q    <= 2'h0;
			irq_q      <= 1'b0;
			dev_rst_q  <= 1'b0;
			pcsp_rst_q <= 1'b0;
		end else begin
			key_flag_q <= key_fire | (key_flag_q & ~cause_clr);
			// Halt clears the timeout flag unless a timeout lands with it
			to_flag_q  <= cif.expire | (to_flag_q & ~halt_i);
			istat_q    <= istat_d;
			if (wr_imask) begin
				imask_q <= wdata_q[1:0];
			end
			irq_q      <= |(istat_d & (wr_imask ? wdata_q[1:0] : imask_q));
			dev_rst_q  <= dev_fire;
			pcsp_rst_q <= to_sleep;
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			awrdy_q  <= 1'b0;
			wrdy_q   <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			waddr_q  <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= kwd_pkg::RESP_OKAY;
		end else begin
			awrdy_q <= ~aw_got_q & ~awrdy_q & s_axi_awvalid & ~bvalid_q;
			wrdy_q  <= ~w_got_q & ~wrdy_q & s_axi_wvalid & ~bvalid_q;
			if (awrdy_q && s_axi_awvalid) begin
				aw_got_q <= 1'b1;
				waddr_q  <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (wrdy_q && s_axi_wvalid) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? kwd_pkg::RESP_OKAY : kwd_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel: one read in flight, data sampled at acceptance
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			arrdy_q  <= 1'b0;
			raddr_q  <= 8'h00;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= kwd_pkg::RESP_OKAY;
		end else begin
			arrdy_q <= ~arrdy_q & ~rvalid_q & s_axi_arvalid;
			if (rd_go) begin
				raddr_q  <= {s_axi_araddr[7:2], 2'b00};
				rvalid_q <= 1'b1;
				rdata_q  <= rd_val;
				rresp_q  <= rd_hit ? kwd_pkg::RESP_OKAY : kwd_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign dev_reset_o           = dev_rst_q;
	assign pc_sp_reset_o         = pcsp_rst_q;
	assign timeout_status_flag_o = to_flag_q;
	assign irq_o                 = irq_q;
	assign s_axi_awready         = awrdy_q;
	assign s_axi_wready          = wrdy_q;
	assign s_axi_bvalid          = bvalid_q;
	assign s_axi_bresp           = bresp_q;
	assign s_axi_arready         = arrdy_q;
	assign s_axi_rvalid          = rvalid_q;
	assign s_axi_rdata           = rdata_q;
	assign s_axi_rresp           = rresp_q;

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_key_armed;
		key_bad && !pend_q && !dev_fire;
	endsequence

	// Ticks seen while a key reset is armed; real tick spacing overflows any delay range
	logic [2:0] pend_tk_q;
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_tk_q <= 3'h0;
		end else if (!pend_q) begin
			pend_tk_q <= 3'h0;
		end else if (cif.tick && pend_tk_q != 3'h7) begin
			pend_tk_q <= pend_tk_q + 3'h1;
		end
	end

	a_key_arms: assert property (s_key_armed |=> pend_q && !cif.run)
		else $error("bad key did not arm reset");

	a_key_fire_rst: assert property (key_fire |=> dev_reset_o && key_flag_q && ctrl_q == 8'h53)
		else $error("key reset did not pulse");

	a_key_flag_hold: assert property (key_flag_q && !cause_clr |=> key_flag_q)
		else $error("key reset flag dropped");

	a_key_flag_set: assert property (key_fire |=> key_flag_q)
		else $error("key reset flag not set");

	a_cause_upper: assert property (s_axi_rvalid && raddr_q == 8'h04 |-> s_axi_rdata[31:1] == 31'h0)
		else $error("cause register upper bits nonzero");

	a_run_key: assert property (cif.run |-> key == 5'h0A)
		else $error("counter ran without enable key");

	a_disabled_idle: assert property (key == 5'h15 && !cif.clear |=> $stable(cif.count))
		else $error("disabled counter moved");

	a_expire_ratio: assert property (cif.tick && cif.run && !cif.clear &&
		cif.count >= kwd_pkg::ratio_m1(cif.sel) |=> cif.expire && cif.count == 18'h0)
		else $error("expiry not at selected ratio");

	a_wake_reset: assert property (cif.expire && !sleep_i |=> dev_reset_o && !pc_sp_reset_o &&
		timeout_status_flag_o)
		else $error("awake timeout did not reset device");

	a_sleep_reset: assert property (cif.expire && sleep_i |=> pc_sp_reset_o && !dev_reset_o &&
		timeout_status_flag_o)
		else $error("sleep timeout wrong reset");

	a_clear_count: assert property (clear_watchdog_instruction_i || halt_i |=> cif.count == 18'h0)
		else $error("counter not cleared");

	a_ctrl_power_on: assert property ($fell(sys_rst_i) |-> ctrl_q == 8'h53)
		else $error("control not at power-on value");

	a_fire_bound: assert property (pend_q |-> pend_tk_q <= 3'(kwd_pkg::KEY_FIRE_TICK))
		else $error("armed key reset never fired");

	a_fire_not_early: assert property (key_fire |-> pend_tk_q == 3'(kwd_pkg::KEY_FIRE_TICK))
		else $error("key reset fired too early");

	a_pend_hold: assert property (pend_q && !key_fire |=> pend_q)
		else $error("armed key reset withdrawn");

	a_dev_pulse: assert property (dev_reset_o |=> !dev_reset_o)
		else $error("device reset longer than one cycle");

	a_pcsp_pulse: assert property (pc_sp_reset_o |=> !pc_sp_reset_o)
		else $error("pc and sp reset longer than one cycle");

	a_reload_wake: assert property (to_wake |=> ctrl_q == kwd_pkg::CTRL_RST)
		else $error("awake timeout did not reload control");

	a_sleep_ctrl: assert property (to_sleep && !wr_ctrl |=> $stable(ctrl_q))
		else $error("sleep timeout changed control");

	a_cause_clear: assert property (cause_clr && !key_fire |=> !key_flag_q)
		else $error("key reset flag not cleared by write of zero");

	a_halt_flag: assert property (halt_i && !cif.expire |=> !timeout_status_flag_o)
		else $error("halt did not clear timeout flag");

	a_istat_timeout: assert property (cif.expire |=> istat_q[kwd_pkg::IRQ_TIMEOUT])
		else $error("timeout event not recorded");

	a_istat_key: assert property (key_fire |=> istat_q[kwd_pkg::IRQ_KEYRST])
		else $error("key reset event not recorded");

	a_irq_level: assert property (irq_o == (|(istat_q & imask_q)))
		else $error("interrupt level does not follow masked status");
endmodule // kwd_top
`default_nettype wire

// [tb/kwd_cpu_model.sv]
// CPU core stand-in: clear and halt instruction strobes, sleep level
// Assumes strobes change just after the rising edge of clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module kwd_cpu_model (
	input  wire logic clk_sys_i,
	output logic      clear_watchdog_instruction_o,
	output logic      halt_o,
	output logic      sleep_o
);
	initial begin
		clear_watchdog_instruction_o = 1'b0;
		halt_o    = 1'b0;
		sleep_o   = 1'b0;
	end

	// One of two instructions that clear the counter; halt is the other
	task automatic do_clr();
		@(posedge clk_sys_i) clear_watchdog_instruction_o <= 1'b1;
		@(posedge clk_sys_i) clear_watchdog_instruction_o <= 1'b0;
	endtask

	task automatic do_halt(input logic slp);
		@(posedge clk_sys_i) begin
			halt_o  <= 1'b1;
			sleep_o <= slp;
		end
		@(posedge clk_sys_i) halt_o <= 1'b0;
	endtask

	task automatic wake();
		@(posedge clk_sys_i) sleep_o <= 1'b0;
	endtask

	// Gap must stay below the selected period, or the device resets
	task automatic service(input int times, input int gap);
		int k;
		for (k = 0; k < times; k++) begin
			repeat (gap) @(posedge clk_sys_i);
			do_clr();
		end
	endtask
endmodule // kwd_cpu_model
`default_nettype wire

// [tb/keyed_watchdog_timer_bench.sv]
// Self-checking bench for the keyed watchdog over AXI4-Lite
// Assumes the slow oscillator runs at one eighth of the system clock
`timescale 1ns/1ps
`default_nettype none
module keyed_watchdog_timer_bench;
	localparam logic [1:0] OK  = kwd_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = kwd_pkg::RESP_SLVERR;
	localparam int RATIO [3] = '{256, 1024, 4096};
	logic        clk_sys_i, sys_rst_i, low_speed_internal_osc_clk_i, clear_watchdog_instruction_i, halt_i, sleep_i;
	logic        dev_reset_o, pc_sp_reset_o, timeout_status_flag_o, irq_o;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, osc_phase;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          n_errors, samples_checked, n_dev, n_pcsp, c, s, nd;

	kwd_top u_kwd_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .low_speed_internal_osc_clk_i(low_speed_internal_osc_clk_i),
		.clear_watchdog_instruction_i(clear_watchdog_instruction_i), .halt_i(halt_i), .sleep_i(sleep_i), .dev_reset_o(dev_reset_o),
		.pc_sp_reset_o(pc_sp_reset_o), .timeout_status_flag_o(timeout_status_flag_o),
		.irq_o(irq_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	kwd_cpu_model u_kwd_cpu_model (.clk_sys_i(clk_sys_i), .clear_watchdog_instruction_o(clear_watchdog_instruction_i),
		.halt_o(halt_i), .sleep_o(sleep_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Slow oscillator at eight system clocks per period keeps runs short
	always @(posedge clk_sys_i) begin
		osc_phase <= osc_phase + 2'h1;
		if (osc_phase == 2'h3) low_speed_internal_osc_clk_i <= ~low_speed_internal_osc_clk_i;
		if (dev_reset_o === 1'b1) n_dev <= n_dev + 1;
		if (pc_sp_reset_o === 1'b1) n_pcsp <= n_pcsp + 1;
	end

	task automatic end_sim();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic give_up(input int n, input int lim);
		if (n >= lim) begin
			n_errors++;
			$display("BAD wait exp answer got timeout");
			end_sim();
		end
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
		samples_checked++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100 && !(aw_done && w_done); n++) begin
			@(posedge clk_sys_i);
			if (s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		give_up(n, 100);
		for (n = 0; n < 100 && s_axi_bvalid !== 1'b1; n++) @(posedge clk_sys_i);
		give_up(n, 100);
		s_axi_bready <= 1'b0;
		cmp("bresp", 32'(OK), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100 && s_axi_arready !== 1'b1; n++) @(posedge clk_sys_i);
		give_up(n, 100);
		s_axi_arvalid <= 1'b0;
		for (n = 0; n < 100 && s_axi_rvalid !== 1'b1; n++) @(posedge clk_sys_i);
		give_up(n, 100);
		s_axi_rready <= 1'b0;
		cmp($sformatf("rdata %h", a), ed, s_axi_rdata);
		cmp("rresp", 32'(er), 32'(s_axi_rresp));
	endtask
	task automatic wait_pulse(input logic pcsp, output int cy);
		for (cy = 0; cy < 40000; cy++) begin
			@(posedge clk_sys_i);
			if ((pcsp ? pc_sp_reset_o : dev_reset_o) === 1'b1) break;
		end
		give_up(cy, 40000);
	endtask

	initial begin
		{sys_rst_i, low_speed_internal_osc_clk_i, osc_phase} = 4'hC;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		n_errors = 0;
		samples_checked = 0;
		n_dev = 0;
		n_pcsp = 0;
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rd(kwd_pkg::OFF_CTRL, 32'h0000_0053, OK);
		rd(kwd_pkg::OFF_CAUSE, 32'h0000_0000, OK);
		rd(8'h20, 32'h0000_0000, ERR);
		for (s = 0; s < 3; s++) begin
			wr(kwd_pkg::OFF_CTRL, 32'h0000_0050 | s);
			u_kwd_cpu_model.do_clr();
			wait_pulse(1'b0, c);
			cmp_rng("period", RATIO[s] * 8 - 8, RATIO[s] * 8 + 4, c);
			cmp("flag", 32'h1, 32'(timeout_status_flag_o));
		end
		rd(kwd_pkg::OFF_ISTAT, 32'h0000_0001, OK);
		wr(kwd_pkg::OFF_IMASK, 32'h0000_0001);
		repeat (2) @(posedge clk_sys_i);
		cmp("irq", 32'h1, 32'(irq_o));
		wr(kwd_pkg::OFF_ISTAT, 32'h0000_0001);
		repeat (2) @(posedge clk_sys_i);
		cmp("irq", 32'h0, 32'(irq_o));
		// Serviced in time: no reset across three periods
		wr(kwd_pkg::OFF_CTRL, 32'h0000_0050);
		nd = n_dev;
		u_kwd_cpu_model.service(4, 1500);
		cmp("serviced", nd, n_dev);
		u_kwd_cpu_model.do_halt(1'b1);
		// Flag settles one edge after the halt strobe is taken
		@(posedge clk_sys_i);
		cmp("flag", 32'h0, 32'(timeout_status_flag_o));
		wait_pulse(1'b1, c);
		cmp_rng("sleep period", 2040, 2052, c);
		cmp("sleep dev", nd, n_dev);
		cmp("flag", 32'h1, 32'(timeout_status_flag_o));
		u_kwd_cpu_model.wake();
		cmp("pcsp count", 32'h1, 32'(n_pcsp));
		wr(kwd_pkg::OFF_CTRL, 32'h0000_00A8);
		repeat (3000) @(posedge clk_sys_i);
		cmp("disabled", nd, n_dev);
		rd(kwd_pkg::OFF_STATUS, 32'h0000_0009, OK);
		wr(kwd_pkg::OFF_CTRL, 32'h0000_0050);
		rd(kwd_pkg::OFF_STATUS, 32'h0000_0005, OK);
		for (s = 0; s < 2; s++) begin
			wr(kwd_pkg::OFF_CTRL, s ? 32'h0000_00F8 : 32'h0000_0000);
			wait_pulse(1'b0, c);
			cmp_rng("key delay", 13, 30, c);
			rd(kwd_pkg::OFF_CAUSE, 32'h0000_0001, OK);
			rd(kwd_pkg::OFF_CTRL, 32'h0000_0053, OK);
		end
		wr(kwd_pkg::OFF_CAUSE, 32'h0000_0001);
		rd(kwd_pkg::OFF_CAUSE, 32'h0000_0001, OK);
		wr(kwd_pkg::OFF_CAUSE, 32'h0000_0000);
		rd(kwd_pkg::OFF_CAUSE, 32'h0000_0000, OK);
		end_sim();
	end
endmodule // keyed_watchdog_timer_bench
`default_nettype wire
